/* File: include/dcm_pkg.sv */
// constants and types for the density calculation mode register bank
// Function
// - mode 0 bypasses calculation, fraction full
// - modes 1-3 pick oil tables, volume from standard
// - mode 4 net oil fraction, volume by portion
// - mode 5 main percentage from main density
// - mode 6 accepted only with special function
// - mode 7 percentage from both densities
// - substance densities used in modes 4, 5
// - mode 4 main density range check sets bit 13
// - mode 4 water density range check sets bit 13
// - mode 5 densities must differ over ten percent
// - filter density results with register time constant
// - densities read in selected density unit
// - holding registers, writes need service level
package dcm_pkg;
  localparam logic [15:0] ADDR_MODE = 16'h683A;
  localparam logic [15:0] ADDR_MAIN = 16'h683C;
  localparam logic [15:0] ADDR_ADD = 16'h683E;
  localparam logic [15:0] ADDR_TAU = 16'h6848;
  localparam logic [31:0] MODE_NONE = 32'h0000_0000;
  localparam logic [31:0] MODE_CRUDE = 32'h0000_0001;
  localparam logic [31:0] MODE_LUBE = 32'h0000_0003;
  localparam logic [31:0] MODE_NETOIL = 32'h0000_0004;
  localparam logic [31:0] MODE_PCT = 32'h0000_0005;
  localparam logic [31:0] MODE_SPEC1 = 32'h0000_0006;
  localparam logic [31:0] MODE_PCT2 = 32'h0000_0007;
  localparam int MODE_COUNT = 8;
  localparam logic [31:0] RST_MODE = MODE_NONE;
  localparam logic [31:0] RST_DENS = 32'h0000_0000;
  localparam logic [31:0] RST_TAU = 32'h4000_0000;
  // density units understood by the range checks
  localparam logic [31:0] UNIT_KGM3 = 32'h0000_0000;
  localparam logic [31:0] UNIT_GCM3 = 32'h0000_0001;
  // float32 range limits, kg/m3 then g/cm3
  localparam logic [31:0] OIL_LO_KG = 32'h4418_A666;
  localparam logic [31:0] OIL_HI_KG = 32'h4491_7000;
  localparam logic [31:0] WAT_LO_KG = 32'h4479_4000;
  localparam logic [31:0] WAT_HI_KG = 32'h44A2_8000;
  localparam logic [31:0] OIL_LO_G = 32'h3F1C_5048;
  localparam logic [31:0] OIL_HI_G = 32'h3F94_ED91;
  localparam logic [31:0] WAT_LO_G = 32'h3F7F_3B64;
  localparam logic [31:0] WAT_HI_G = 32'h3FA6_6666;
  // 1.1 and 0.9 as Q1.23 mantissa plus exponent step
  localparam logic [23:0] K_HI_MANT = 24'h8CCCCD;
  localparam logic [7:0] K_HI_EXP = 8'h00;
  localparam logic [23:0] K_LO_MANT = 24'hE66666;
  localparam logic [7:0] K_LO_EXP = 8'hFF;
  localparam int F_BIAS = 127;
  localparam logic [7:0] F_EXP_ZERO = 8'h00;
  // measurement samples are unsigned Q16.16
  localparam logic [31:0] FRAC_FULL = 32'h0064_0000;
  localparam int ERR_BIT = 13;
  // update interval is 2**DT_LOG2 seconds
  localparam int DT_LOG2 = -6;
  localparam int FILT_K_MAX = 15;
  localparam logic [3:0] FILT_K_MAXV = 4'hF;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_ACCESS = 8'h04;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } dcm_state_e;
endpackage : dcm_pkg

/* File: rtl/dcm_mode_config.sv */
// density calculation mode register bank with checks and filter
`timescale 1ns/1ps
module dcm_mode_config (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // holding register access from the protocol engine
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [15:0] reqAddr,
  input wire logic [31:0] reqWdata,
  output logic reqReady,
  output logic rspValid,
  output logic [31:0] rspRdata,
  output logic [7:0] rspExc,
  // access level and unit context
  input wire logic serviceLevel,
  input wire logic special1Avail,
  input wire logic [31:0] densityUnitSel,
  // measurement samples
  input wire logic sampleValid,
  input wire logic [31:0] compDensity,
  input wire logic [31:0] calcStdDensity,
  input wire logic [31:0] calcFraction,
  // results and calculation steering
  output logic [31:0] densityFiltered,
  output logic [31:0] stdDensityResult,
  output logic [31:0] mainVolumeFraction,
  output logic [7:0] modeOneHot,
  output logic volFromStd,
  output logic volByFraction,
  output logic useSubstance,
  output logic [31:0] errorFlagWord
);
  import dcm_pkg::*;

  typedef struct packed {
    dcm_state_e st;
    logic [31:0] mode;
    logic [31:0] dMain;
    logic [31:0] dAdd;
    logic [31:0] tau;
    logic rspValid;
    logic [31:0] rspData;
    logic [7:0] rspExc;
    logic [3:0] filtK;
    logic [31:0] densF;
    logic [31:0] stdF;
    logic [31:0] frac;
    logic [7:0] modeHot;
    logic volStd;
    logic volFrac;
    logic useSub;
    logic [31:0] errWord;
  } dcm_state_s;

  dcm_state_s s_q;
  dcm_state_s s_d;

  // positive float in closed range; bit patterns order like values
  function automatic logic inRange(input logic [31:0] v,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
    return !v[31] && (v >= lo) && (v <= hi);
  endfunction : inRange

  // positive float times a constant mantissa and exponent step
  function automatic logic [31:0] scaleF(input logic [31:0] f,
                                         input logic [23:0] k,
                                         input logic [7:0] eAdj);
    logic [47:0] p;
    logic [7:0] e;
    p = {1'b1, f[22:0]} * k;
    e = f[30:23] + eAdj + {7'h00, p[47]};
    if (f[30:23] == F_EXP_ZERO) begin
      return 32'h0000_0000;
    end
    return p[47] ? {1'b0, e, p[46:24]} : {1'b0, e, p[45:23]};
  endfunction : scaleF

  // shift k with 2**-k close to interval over tau
  function automatic logic [3:0] tauShift(input logic [31:0] t);
    int e;
    e = int'(t[30:23]) - F_BIAS + int'(t[22]) - DT_LOG2;
    if (t[31] || t[30:23] == F_EXP_ZERO || e < 0) begin
      return 4'h0;
    end
    if (e > FILT_K_MAX) begin
      return FILT_K_MAXV;
    end
    return e[3:0];
  endfunction : tauShift

  // first-order low pass step
  function automatic logic [31:0] lowPass(input logic [31:0] y,
                                          input logic [31:0] x,
                                          input logic [3:0] k);
    logic signed [32:0] diff;
    logic signed [32:0] step;
    diff = $signed({1'b0, x}) - $signed({1'b0, y});
    step = diff >>> k;
    return y + step[31:0];
  endfunction : lowPass

  function automatic logic isMapped(input logic [15:0] a);
    return a == ADDR_MODE || a == ADDR_MAIN || a == ADDR_ADD ||
           a == ADDR_TAU;
  endfunction : isMapped

  function automatic logic modeOk(input logic [31:0] m,
                                  input logic avail);
    return m < MODE_COUNT && (m != MODE_SPEC1 || avail);
  endfunction : modeOk

  logic [31:0] oilLo;
  logic [31:0] oilHi;
  logic [31:0] watLo;
  logic [31:0] watHi;
  logic unitOk;
  logic rangeErr;
  logic diffErr;

  // limits follow the selected density unit
  always_comb begin
    unitOk = 1'b1;
    oilLo = OIL_LO_KG;
    oilHi = OIL_HI_KG;
    watLo = WAT_LO_KG;
    watHi = WAT_HI_KG;
    if (densityUnitSel == UNIT_GCM3) begin
      oilLo = OIL_LO_G;
      oilHi = OIL_HI_G;
      watLo = WAT_LO_G;
      watHi = WAT_HI_G;
    end else if (densityUnitSel != UNIT_KGM3) begin
      unitOk = 1'b0;
    end
  end

  always_comb begin
    rangeErr = !unitOk ||
      !inRange(s_q.dMain, oilLo, oilHi) ||
      !inRange(s_q.dAdd, watLo, watHi);
    diffErr = s_q.dMain[31] || s_q.dAdd[31] ||
      !((s_q.dAdd > scaleF(s_q.dMain, K_HI_MANT, K_HI_EXP)) ||
        (s_q.dAdd < scaleF(s_q.dMain, K_LO_MANT, K_LO_EXP)));
  end

  always_comb begin
    s_d = s_q;
    s_d.rspValid = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (reqValid) begin
          s_d.st = ST_RESP;
          s_d.rspValid = 1'b1;
          s_d.rspExc = EXC_NONE;
          s_d.rspData = 32'h0000_0000;
          if (!isMapped(reqAddr)) begin
            s_d.rspExc = EXC_ADDR;
          end else if (reqWrite) begin
            if (!serviceLevel) begin
              s_d.rspExc = EXC_ACCESS;
            end else if (reqAddr == ADDR_MODE) begin
              if (modeOk(reqWdata, special1Avail)) begin
                s_d.mode = reqWdata;
              end else begin
                s_d.rspExc = EXC_VALUE;
              end
            end else if (reqAddr == ADDR_MAIN) begin
              s_d.dMain = reqWdata;
            end else if (reqAddr == ADDR_ADD) begin
              s_d.dAdd = reqWdata;
            end else begin
              s_d.tau = reqWdata;
            end
          end else begin
            case (reqAddr)
              ADDR_MODE: s_d.rspData = s_q.mode;
              ADDR_MAIN: s_d.rspData = s_q.dMain;
              ADDR_ADD: s_d.rspData = s_q.dAdd;
              default: s_d.rspData = s_q.tau;
            endcase
          end
        end
      end
      ST_RESP: begin
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // calculation steering from the stored mode
    s_d.modeHot = 8'h00;
    s_d.modeHot[s_q.mode[2:0]] = 1'b1;
    s_d.volStd = s_q.mode >= MODE_CRUDE && s_q.mode <= MODE_LUBE;
    s_d.volFrac = s_q.mode == MODE_NETOIL ||
                  s_q.mode == MODE_PCT ||
                  s_q.mode == MODE_PCT2;
    s_d.useSub = s_q.mode == MODE_NETOIL || s_q.mode == MODE_PCT;
    s_d.errWord = 32'h0000_0000;
    s_d.errWord[ERR_BIT] = (s_q.mode == MODE_NETOIL && rangeErr) ||
                           (s_q.mode == MODE_PCT && diffErr);
    s_d.filtK = tauShift(s_q.tau);
    if (sampleValid) begin
      s_d.densF = lowPass(s_q.densF, compDensity, s_q.filtK);
      if (s_q.mode == MODE_NONE) begin
        s_d.stdF = lowPass(s_q.stdF, compDensity, s_q.filtK);
        s_d.frac = FRAC_FULL;
      end else begin
        s_d.stdF = lowPass(s_q.stdF, calcStdDensity, s_q.filtK);
        s_d.frac = calcFraction;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{st: ST_IDLE, mode: RST_MODE, dMain: RST_DENS,
               dAdd: RST_DENS, tau: RST_TAU, frac: FRAC_FULL,
               modeHot: 8'h01, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reqReady = s_q.st[0];
  assign rspValid = s_q.rspValid;
  assign rspRdata = s_q.rspData;
  assign rspExc = s_q.rspExc;
  assign densityFiltered = s_q.densF;
  assign stdDensityResult = s_q.stdF;
  assign mainVolumeFraction = s_q.frac;
  assign modeOneHot = s_q.modeHot;
  assign volFromStd = s_q.volStd;
  assign volByFraction = s_q.volFrac;
  assign useSubstance = s_q.useSub;
  assign errorFlagWord = s_q.errWord;

  sequence sWriteTaken(logic [15:0] a);
    s_q.st == ST_IDLE && reqValid && reqWrite && reqAddr == a;
  endsequence

  sequence sSample(logic [31:0] m);
    sampleValid && s_q.mode == m;
  endsequence

  a_mode0_fraction: assert property (
    @(posedge clk) disable iff (!rstn)
    sSample(MODE_NONE) |=> mainVolumeFraction == FRAC_FULL)
    else $error("fraction not full in mode 0");

  a_mode0_stdbypass: assert property (
    @(posedge clk) disable iff (!rstn)
    sSample(MODE_NONE) and (s_q.filtK == 4'h0)
    |=> stdDensityResult == $past(compDensity))
    else $error("standard density not compensated density");

  a_oil_volume: assert property (
    @(posedge clk) disable iff (!rstn)
    s_q.mode >= MODE_CRUDE && s_q.mode <= MODE_LUBE
    |=> volFromStd && !volByFraction)
    else $error("oil table mode lost volume source");

  a_portion_volume: assert property (
    @(posedge clk) disable iff (!rstn)
    s_q.mode == MODE_NETOIL || s_q.mode == MODE_PCT ||
    s_q.mode == MODE_PCT2 |=> volByFraction && !volFromStd)
    else $error("portion mode lost fraction scaling");

  a_pct_onehot: assert property (
    @(posedge clk) disable iff (!rstn)
    s_q.mode == MODE_PCT ##1 s_q.mode == MODE_PCT
    |-> modeOneHot == 8'h20)
    else $error("mode 5 one-hot wrong");

  a_spec1_gate: assert property (
    @(posedge clk) disable iff (!rstn)
    sWriteTaken(ADDR_MODE) and (serviceLevel && !special1Avail &&
    reqWdata == MODE_SPEC1) |=> rspExc == EXC_VALUE &&
    $stable(s_q.mode))
    else $error("mode 6 accepted without special function");

  a_pct2_onehot: assert property (
    @(posedge clk) disable iff (!rstn)
    s_q.mode == MODE_PCT2 ##1 s_q.mode == MODE_PCT2
    |-> modeOneHot == 8'h80 && volByFraction)
    else $error("mode 7 steering wrong");

  a_subst_use: assert property (
    @(posedge clk) disable iff (!rstn)
    ##1 useSubstance == ($past(s_q.mode) == MODE_NETOIL ||
    $past(s_q.mode) == MODE_PCT))
    else $error("substance density use wrong");

  a_netoil_range: assert property (
    @(posedge clk) disable iff (!rstn)
    s_q.mode == MODE_NETOIL && densityUnitSel == UNIT_KGM3 &&
    (s_q.dMain < OIL_LO_KG || s_q.dMain > OIL_HI_KG)
    |=> errorFlagWord[ERR_BIT])
    else $error("main density range error missed");

  a_water_range: assert property (
    @(posedge clk) disable iff (!rstn)
    s_q.mode == MODE_NETOIL && densityUnitSel == UNIT_KGM3 &&
    (s_q.dAdd < WAT_LO_KG || s_q.dAdd > WAT_HI_KG)
    |=> errorFlagWord[ERR_BIT])
    else $error("water density range error missed");

  a_pct_equal: assert property (
    @(posedge clk) disable iff (!rstn)
    s_q.mode == MODE_PCT && s_q.dAdd == s_q.dMain
    |=> errorFlagWord[ERR_BIT])
    else $error("equal densities not flagged");

  a_no_service: assert property (
    @(posedge clk) disable iff (!rstn)
    sWriteTaken(ADDR_TAU) and !serviceLevel
    |=> rspValid && rspExc == EXC_ACCESS && $stable(s_q.tau))
    else $error("write accepted without service level");

endmodule : dcm_mode_config

/* File: verif/dcm_host_model.sv */
// host model issuing holding register reads and writes
`timescale 1ns/1ps
module dcm_host_model (
  // clock
  input wire logic clk,
  // register port toward the bank
  output logic reqValid,
  output logic reqWrite,
  output logic [15:0] reqAddr,
  output logic [31:0] reqWdata,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic [31:0] rspRdata,
  input wire logic [7:0] rspExc
);
  initial begin
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 16'h0000;
    reqWdata = 32'h0000_0000;
  end

  // one access, held until taken or ten cycles pass; EE marks no answer
  task automatic access(input logic wr, input logic [15:0] addr,
      input logic [31:0] wdata, output logic [31:0] rdata,
      output logic [7:0] exc);
    int n;
    @(posedge clk);
    #5;
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = addr;
    reqWdata = wdata;
    n = 0;
    // ready is looked at between edges, where it is settled
    while (reqReady !== 1'b1 && n < 10) begin
      @(posedge clk);
      #5;
      n++;
    end
    @(posedge clk);
    #5;
    exc = (rspValid === 1'b1) ? rspExc : 8'hEE;
    rdata = rspRdata;
    reqValid = 1'b0;
    reqAddr = ~addr;
    reqWdata = ~wdata;
  endtask : access
endmodule : dcm_host_model

/* File: verif/tb.sv */
// self-checking bench for the density calculation mode register bank
`timescale 1ns/1ps
module tb;
  import dcm_pkg::*;
  logic clk, rstn, reqValid, reqWrite, reqReady, rspValid;
  logic [15:0] reqAddr;
  logic [31:0] reqWdata, rspRdata, densityUnitSel, compDensity;
  logic [31:0] calcStdDensity, calcFraction, densityFiltered;
  logic [31:0] stdDensityResult, mainVolumeFraction, errorFlagWord;
  logic [7:0] rspExc, modeOneHot, ex;
  logic serviceLevel, special1Avail, sampleValid;
  logic volFromStd, volByFraction, useSubstance;
  logic [31:0] rd;
  int errTotal = 0;
  int testsRun = 0;

  dcm_mode_config dut (.clk(clk), .rstn(rstn), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata),
    .rspExc(rspExc), .serviceLevel(serviceLevel),
    .special1Avail(special1Avail), .densityUnitSel(densityUnitSel),
    .sampleValid(sampleValid), .compDensity(compDensity),
    .calcStdDensity(calcStdDensity), .calcFraction(calcFraction),
    .densityFiltered(densityFiltered), .stdDensityResult(stdDensityResult),
    .mainVolumeFraction(mainVolumeFraction), .modeOneHot(modeOneHot),
    .volFromStd(volFromStd), .volByFraction(volByFraction),
    .useSubstance(useSubstance), .errorFlagWord(errorFlagWord));
  dcm_host_model host (.clk(clk), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata),
    .rspExc(rspExc));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    if (errTotal == 0 && testsRun > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // write, check the code, let steering settle
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
      input logic [7:0] e);
    host.access(1'b1, a, d, rd, ex);
    chk("write code", {24'h0, e}, {24'h0, ex});
    repeat (2) @(posedge clk);
    #5;
  endtask : wr

  task automatic rdchk(input logic [15:0] a, input logic [31:0] d);
    host.access(1'b0, a, 32'h0, rd, ex);
    chk("read code", 32'h0, {24'h0, ex});
    chk("read data", d, rd);
  endtask : rdchk

  task automatic sample(input logic [31:0] c, s, f);
    @(posedge clk);
    #5;
    compDensity = c;
    calcStdDensity = s;
    calcFraction = f;
    sampleValid = 1'b1;
    @(posedge clk);
    #5;
    sampleValid = 1'b0;
  endtask : sample

  task automatic t_reset();
    chk("fraction", FRAC_FULL, mainVolumeFraction);
    chk("one hot", 32'h01, {24'h0, modeOneHot});
    rdchk(ADDR_MODE, MODE_NONE);
    rdchk(ADDR_MAIN, RST_DENS);
    rdchk(ADDR_ADD, RST_DENS);
    rdchk(ADDR_TAU, 32'h4000_0000);
  endtask : t_reset

  task automatic t_filter();
    sample(32'h0080_0000, 32'h0040_0000, 32'h0012_0000);
    chk("filtered", 32'h0001_0000, densityFiltered);
    chk("std result", 32'h0001_0000, stdDensityResult);
    chk("fraction", FRAC_FULL, mainVolumeFraction);
    wr(ADDR_TAU, 32'h0000_0000, EXC_NONE);
    sample(32'h0077_0000, 32'h0011_0000, 32'h0022_0000);
    chk("std result", 32'h0077_0000, stdDensityResult);
    chk("fraction", FRAC_FULL, mainVolumeFraction);
    wr(ADDR_MODE, MODE_NETOIL, EXC_NONE);
    sample(32'h0123_0000, 32'h0045_6000, 32'h0033_0000);
    chk("filtered", 32'h0123_0000, densityFiltered);
    chk("std result", 32'h0045_6000, stdDensityResult);
    chk("fraction", 32'h0033_0000, mainVolumeFraction);
  endtask : t_filter

  task automatic t_access();
    serviceLevel = 1'b0;
    wr(ADDR_TAU, 32'h3F80_0000, EXC_ACCESS);
    serviceLevel = 1'b1;
    rdchk(ADDR_TAU, 32'h0000_0000);
    wr(16'h6840, 32'h0000_0001, EXC_ADDR);
  endtask : t_access

  task automatic t_modes();
    special1Avail = 1'b1;
    for (int i = 0; i < MODE_COUNT; i++) begin
      wr(ADDR_MODE, 32'(i), EXC_NONE);
      chk("one hot", {24'h0, 8'h01 << i}, {24'h0, modeOneHot});
      chk("from std", 32'(i >= 1 && i <= 3), 32'(volFromStd));
      chk("by fraction", 32'(i == 4 || i == 5 || i == 7),
          32'(volByFraction));
      chk("use subst", 32'(i == 4 || i == 5), 32'(useSubstance));
    end
    special1Avail = 1'b0;
    wr(ADDR_MODE, MODE_SPEC1, EXC_VALUE);
    wr(ADDR_MODE, 32'h0000_0008, EXC_VALUE);
    rdchk(ADDR_MODE, MODE_PCT2);
  endtask : t_modes

  // densities at reference conditions for mode 4, live for mode 5
  task automatic t_ranges();
    wr(ADDR_MODE, MODE_NETOIL, EXC_NONE);
    wr(ADDR_MAIN, 32'h442F_0000, EXC_NONE);
    wr(ADDR_ADD, 32'h447A_0000, EXC_NONE);
    chk("error word", 32'h0, errorFlagWord);
    wr(ADDR_MAIN, 32'h4416_0000, EXC_NONE);
    chk("error word", 32'h2000, errorFlagWord);
    wr(ADDR_MAIN, 32'h442F_0000, EXC_NONE);
    wr(ADDR_ADD, 32'h4477_8000, EXC_NONE);
    chk("error word", 32'h2000, errorFlagWord);
    wr(ADDR_ADD, 32'h44A5_0000, EXC_NONE);
    chk("error word", 32'h2000, errorFlagWord);
    wr(ADDR_MODE, MODE_PCT, EXC_NONE);
    wr(ADDR_MAIN, 32'h447A_0000, EXC_NONE);
    wr(ADDR_ADD, 32'h4483_4000, EXC_NONE);
    chk("error word", 32'h2000, errorFlagWord);
    wr(ADDR_ADD, 32'h4496_0000, EXC_NONE);
    chk("error word", 32'h0, errorFlagWord);
    wr(ADDR_ADD, 32'h4448_0000, EXC_NONE);
    chk("error word", 32'h0, errorFlagWord);
    wr(ADDR_MODE, MODE_NETOIL, EXC_NONE);
    wr(ADDR_MAIN, 32'h3F33_3333, EXC_NONE);
    wr(ADDR_ADD, 32'h3F80_0000, EXC_NONE);
    densityUnitSel = UNIT_GCM3;
    repeat (3) @(posedge clk);
    #5;
    chk("error word", 32'h0, errorFlagWord);
    densityUnitSel = 32'h0000_0002;
    repeat (3) @(posedge clk);
    #5;
    chk("error word", 32'h2000, errorFlagWord);
    densityUnitSel = UNIT_KGM3;
    repeat (3) @(posedge clk);
    #5;
    chk("error word", 32'h2000, errorFlagWord);
  endtask : t_ranges

  initial begin
    #1_000_000;
    errTotal++;
    final_report();
  end

  initial begin
    rstn = 1'b0;
    serviceLevel = 1'b1;
    special1Avail = 1'b0;
    densityUnitSel = UNIT_KGM3;
    sampleValid = 1'b0;
    compDensity = 32'h0;
    calcStdDensity = 32'h0;
    calcFraction = 32'h0;
    repeat (12) @(posedge clk);
    #5;
    rstn = 1'b1;
    t_reset();
    t_filter();
    t_access();
    t_modes();
    t_ranges();
    // reset again in mid-run; the bank must return to defaults
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #5;
    rstn = 1'b1;
    chk("error word", 32'h0, errorFlagWord);
    t_reset();
    final_report();
  end
endmodule : tb
